// [include/hours_pkg.sv]
// Purpose: Shared constants and types of the operating-hours and service-interval counter.
// Assumes: 20 MHz system clock; APB register map with one aligned 32-bit word per register.
// Notes:   Every offset, field position, reset value and timing count lives here.

package hours_pkg;

  // ****************************************************************
  // Clock and time base
  // ****************************************************************
  localparam longint unsigned CLK_HZ      = 64'h0000_0000_0131_2D00;
  localparam longint unsigned HOUR_S      = 64'h0000_0000_0000_0E10;
  localparam int unsigned     PRESCALE_W  = 37;
  localparam logic [PRESCALE_W-1:0] HOUR_CYCLES = PRESCALE_W'(CLK_HZ * HOUR_S);

  // ****************************************************************
  // Value ranges
  // ****************************************************************
  localparam int unsigned      INTERVAL_W   = 14;
  localparam int unsigned      TOTAL_W      = 17;
  localparam logic [13:0]      INTERVAL_MAX = 14'h270F;
  localparam logic [16:0]      TOTAL_MAX    = 17'h1_869F;
  localparam logic [4:0]       DIV_LAST     = 5'h10;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_INTERVAL   = 8'h04;
  localparam logic [7:0]  OFF_TOTAL      = 8'h08;
  localparam logic [7:0]  OFF_TTG        = 8'h0C;
  localparam logic [7:0]  OFF_STATUS     = 8'h10;
  localparam logic [7:0]  OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h18;

  localparam int unsigned CTRL_RUN_BIT   = 0;
  localparam int unsigned CTRL_IDLE_BIT  = 1;
  localparam int unsigned STAT_DUE_BIT   = 0;
  localparam int unsigned STAT_RUN_BIT   = 1;
  localparam int unsigned STAT_BUSY_BIT  = 2;
  localparam int unsigned IRQ_W          = 2;
  localparam int unsigned IRQ_DUE_BIT    = 0;
  localparam int unsigned IRQ_SAT_BIT    = 1;
  localparam logic [1:0]  IRQ_MASK_RESET = 2'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic idle_clear;
    logic run;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = '{idle_clear: 1'b0, run: 1'b0};

  typedef enum logic [1:0] {
    ST_STOP,
    ST_DIVIDE,
    ST_RUN
  } run_state_type;

endpackage

// [logic/hour_tick_gen.sv]
// Purpose: Hour prescaler; one tick per hour of enabled time.
// Assumes: enable comes from logic on the same clock.
// Notes:   The partial count is kept while enable is low.

`timescale 1ns/1ns

module hour_tick_gen #(
  parameter int unsigned    W     = hours_pkg::PRESCALE_W,
  parameter logic [W-1:0]   LIMIT = hours_pkg::HOUR_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic enable,
  output logic      tick
);

  logic [W-1:0] count_r;
  logic         at_end;

  assign at_end = (count_r == (LIMIT - W'(1)));
  assign tick   = enable && at_end;

  // Counting pauses rather than restarts, so short runs add up to whole hours.
  always_ff @(posedge clk) begin
    if (reset) begin
      count_r <= '0;
    end else if (tick) begin
      count_r <= '0;
    end else if (enable) begin
      count_r <= count_r + W'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_hold_partial: assert property (!enable |=> $stable(count_r))
    else $error("Prescaler moved while disabled.");

  a_tick_needs_en: assert property (tick |-> enable && count_r == (LIMIT - W'(1)))
    else $error("Hour tick without enable or before the end of the hour.");

endmodule

// [logic/service_hours_counter.sv]
// Purpose: Operating-hours counter with a service interval countdown and due output.
// Assumes: monitor_in, interval_reset and reset_all come from logic on the clk domain.
// Notes:   Values survive a warm reset; only a reset with cold_start high clears them.

`timescale 1ns/1ns

module service_hours_counter #(
  parameter logic [hours_pkg::PRESCALE_W-1:0] HOUR_CYCLES = hours_pkg::HOUR_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        cold_start,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        monitor_in,
  input  wire logic        interval_reset,
  input  wire logic        reset_all,
  output logic             maintenance_due,
  output logic             irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  hours_pkg::ctrl_type      ctrl_r;
  hours_pkg::run_state_type state_r;

  logic [13:0] interval_r;
  logic [13:0] ttg_r;
  logic [16:0] total_r;
  logic [14:0] rem_r;
  logic [14:0] rem_shift;
  logic [14:0] rem_step;
  logic [4:0]  step_r;
  logic        due_r;
  logic        due_nxt;
  logic        irq_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_data;
  logic        addr_hit;
  logic [1:0]  irq_status_r;
  logic [1:0]  irq_mask_r;
  logic [1:0]  irq_event;
  logic [1:0]  irq_clear;
  logic        ir_prev_r;
  logic        ra_prev_r;
  logic        ir_rise;
  logic        ra_rise;
  logic        force_low;
  logic        running;
  logic        count_en;
  logic        tick;
  logic        apb_access;
  logic        apb_done;
  logic        wr_done;
  logic        cfg_write;

  assign running    = (state_r == hours_pkg::ST_RUN);
  assign count_en   = running && monitor_in;
  assign apb_access = psel && penable && !pready_r;
  assign apb_done   = psel && penable && pready_r;
  assign wr_done    = apb_done && pwrite;
  assign cfg_write  = wr_done && (state_r == hours_pkg::ST_STOP);

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign maintenance_due = due_r;
  assign irq             = irq_r;

  // ****************************************************************
  // Hour time base
  // ****************************************************************
  hour_tick_gen #(
    .W     (hours_pkg::PRESCALE_W),
    .LIMIT (HOUR_CYCLES)
  ) u_tick (
    .clk    (clk),
    .reset  (reset),
    .enable (count_en),
    .tick   (tick)
  );

  // ****************************************************************
  // Reset inputs: rising edge detection
  // ****************************************************************
  // An input already high at reset release counts as an edge; it only acts in run.
  always_ff @(posedge clk) begin
    if (reset) begin
      ir_prev_r <= 1'b0;
      ra_prev_r <= 1'b0;
    end else begin
      ir_prev_r <= interval_reset;
      ra_prev_r <= reset_all;
    end
  end

  assign ir_rise = interval_reset && !ir_prev_r;
  assign ra_rise = reset_all && !ra_prev_r;

  // ****************************************************************
  // Control and run sequencing
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= hours_pkg::CTRL_RESET;
    end else if (wr_done && paddr == hours_pkg::OFF_CTRL) begin
      ctrl_r.run        <= pwdata[hours_pkg::CTRL_RUN_BIT];
      ctrl_r.idle_clear <= pwdata[hours_pkg::CTRL_IDLE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= hours_pkg::ST_STOP;
    end else begin
      case (state_r)
        hours_pkg::ST_STOP: begin
          if (ctrl_r.run) begin
            state_r <= hours_pkg::ST_DIVIDE;
          end
        end
        hours_pkg::ST_DIVIDE: begin
          if (step_r == hours_pkg::DIV_LAST) begin
            state_r <= hours_pkg::ST_RUN;
          end
        end
        hours_pkg::ST_RUN: begin
          if (!ctrl_r.run) begin
            state_r <= hours_pkg::ST_STOP;
          end
        end
        default: begin
          state_r <= hours_pkg::ST_STOP;
        end
      endcase
    end
  end

  // ****************************************************************
  // Start-up remainder: restoring division, one bit per cycle
  // ****************************************************************
  // A serial divider costs 17 cycles at start but avoids a wide combinational modulo.
  always_comb begin
    rem_shift = {rem_r[13:0], total_r[hours_pkg::DIV_LAST - step_r]};
    rem_step  = rem_shift;
    if (rem_shift >= {1'b0, interval_r}) begin
      rem_step = rem_shift - {1'b0, interval_r};
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_r != hours_pkg::ST_DIVIDE) begin
      rem_r  <= '0;
      step_r <= '0;
    end else begin
      rem_r  <= rem_step;
      step_r <= step_r + 5'h1;
    end
  end

  // ****************************************************************
  // Retained values
  // ****************************************************************
  // A warm reset leaves these alone so that the counts behave as retentive storage.
  always_ff @(posedge clk) begin
    if (reset) begin
      if (cold_start) begin
        interval_r <= '0;
      end
    end else if (cfg_write && paddr == hours_pkg::OFF_INTERVAL) begin
      if (pwdata > 32'(hours_pkg::INTERVAL_MAX)) begin
        interval_r <= hours_pkg::INTERVAL_MAX;
      end else begin
        interval_r <= pwdata[13:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      if (cold_start) begin
        total_r <= '0;
      end
    end else if (cfg_write && paddr == hours_pkg::OFF_TOTAL) begin
      if (pwdata > 32'(hours_pkg::TOTAL_MAX)) begin
        total_r <= hours_pkg::TOTAL_MAX;
      end else begin
        total_r <= pwdata[16:0];
      end
    end else if (running && ra_rise) begin
      total_r <= '0;
    end else if (tick && total_r != hours_pkg::TOTAL_MAX) begin
      total_r <= total_r + 17'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      if (cold_start) begin
        ttg_r <= '0;
      end
    end else if (state_r == hours_pkg::ST_DIVIDE && step_r == hours_pkg::DIV_LAST) begin
      if (interval_r == '0) begin
        ttg_r <= '0;
      end else begin
        ttg_r <= interval_r - rem_step[13:0];
      end
    end else if (running && (ir_rise || ra_rise)) begin
      ttg_r <= interval_r;
    end else if (tick && ttg_r != '0) begin
      ttg_r <= ttg_r - 14'h1;
    end
  end

  // ****************************************************************
  // Due output
  // ****************************************************************
  assign force_low = interval_reset || reset_all || (ctrl_r.idle_clear && !monitor_in);
  assign due_nxt   = running && (ttg_r == '0) && !force_low;

  always_ff @(posedge clk) begin
    if (reset) begin
      due_r <= 1'b0;
    end else begin
      due_r <= due_nxt;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irq_event[hours_pkg::IRQ_DUE_BIT] = due_nxt && !due_r;
  assign irq_event[hours_pkg::IRQ_SAT_BIT] = tick && !ra_rise
                                             && total_r == (hours_pkg::TOTAL_MAX - 17'h1);
  assign irq_clear = (wr_done && paddr == hours_pkg::OFF_IRQ_STATUS) ? pwdata[1:0] : 2'h0;

  // A new event in the clearing cycle survives the write-one-to-clear.
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_mask_r <= hours_pkg::IRQ_MASK_RESET;
    end else if (wr_done && paddr == hours_pkg::OFF_IRQ_MASK) begin
      irq_mask_r <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_status_r & irq_mask_r);
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  always_comb begin
    rd_data  = '0;
    addr_hit = 1'b1;
    case (paddr)
      hours_pkg::OFF_CTRL: begin
        rd_data[hours_pkg::CTRL_RUN_BIT]  = ctrl_r.run;
        rd_data[hours_pkg::CTRL_IDLE_BIT] = ctrl_r.idle_clear;
      end
      hours_pkg::OFF_INTERVAL:   rd_data[13:0] = interval_r;
      hours_pkg::OFF_TOTAL:      rd_data[16:0] = total_r;
      hours_pkg::OFF_TTG:        rd_data[13:0] = ttg_r;
      hours_pkg::OFF_STATUS: begin
        rd_data[hours_pkg::STAT_DUE_BIT]  = due_r;
        rd_data[hours_pkg::STAT_RUN_BIT]  = running;
        rd_data[hours_pkg::STAT_BUSY_BIT] = (state_r == hours_pkg::ST_DIVIDE);
      end
      hours_pkg::OFF_IRQ_STATUS: rd_data[1:0] = irq_status_r;
      hours_pkg::OFF_IRQ_MASK:   rd_data[1:0] = irq_mask_r;
      default:                   addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= apb_access;
      pslverr_r <= apb_access && !addr_hit;
      if (apb_access && !pwrite) begin
        prdata_r <= rd_data;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [16:0] safe_div;
  logic [13:0] expect_ttg;
  assign safe_div   = (interval_r == '0) ? 17'h1 : {3'h0, interval_r};
  assign expect_ttg = (interval_r == '0) ? 14'h0 : interval_r - 14'(total_r % safe_div);

  sequence s_div_last;
    state_r == hours_pkg::ST_DIVIDE && step_r == hours_pkg::DIV_LAST;
  endsequence

  sequence s_run_start;
    state_r == hours_pkg::ST_STOP && ctrl_r.run ##1 state_r == hours_pkg::ST_DIVIDE;
  endsequence

  a_idle_freeze: assert property (running && !monitor_in && !ir_rise && !ra_rise
    |=> $stable(total_r) && $stable(ttg_r))
    else $error("Counts moved while the monitor input was low.");

  a_due_on_zero: assert property (running && ttg_r == '0 && !force_low |=> due_r)
    else $error("Due output missing at zero time-to-go.");

  a_interval_reload: assert property (running && ir_rise && !ra_rise
    |=> ttg_r == $past(interval_r) && !due_r)
    else $error("Interval reset did not reload time-to-go.");

  a_reset_all_clear: assert property (running && ra_rise
    |=> total_r == '0 && ttg_r == $past(interval_r) && !due_r)
    else $error("Reset-all did not clear total and reload time-to-go.");

  a_due_forced_low: assert property (force_low |=> !due_r)
    else $error("Due output high while a clear condition held.");

  a_total_counts: assert property (tick && !ra_rise && total_r != hours_pkg::TOTAL_MAX
    |=> total_r == $past(total_r) + 17'h1)
    else $error("Total did not advance on an hour tick.");

  a_total_saturate: assert property (total_r == hours_pkg::TOTAL_MAX && running
    && !ra_rise |=> total_r == hours_pkg::TOTAL_MAX)
    else $error("Total left its saturation value.");

  a_interval_range: assert property (interval_r <= hours_pkg::INTERVAL_MAX)
    else $error("Service interval above its range.");

  a_start_ttg: assert property (s_div_last |=> ttg_r == $past(expect_ttg) && running)
    else $error("Starting time-to-go not interval minus remainder.");

  a_start_bound: assert property (s_run_start |-> ##[17:17] running)
    else $error("Run not entered seventeen cycles after start.");

  a_tick_gated: assert property (tick |-> monitor_in && running)
    else $error("Hour tick while the monitor input was low.");

  a_apb_answer: assert property (apb_access |=> pready_r ##1 !pready_r)
    else $error("APB answer not given one cycle into the access phase.");

endmodule

// [verification/logic_source.sv]
// Purpose: Stand-in for the function blocks that feed the counter's monitor and reset inputs.
// Assumes: The bench requests levels on the rising edge; this model adds one clock of delay.
// Notes:   Levels are real logic outputs, so no released or floating state exists here.

`timescale 1ns/1ns

module logic_source (
  input  wire logic       clk,
  input  wire logic [2:0] want,
  output logic            monitor_in,
  output logic            interval_reset,
  output logic            reset_all
);
  initial begin
    monitor_in = 1'b0;
    interval_reset = 1'b0;
    reset_all = 1'b0;
  end

  // A register stage mimics an upstream block that updates once per scan.
  always @(posedge clk) begin
    monitor_in <= want[0];
    interval_reset <= want[1];
    reset_all <= want[2];
  end
endmodule

// [verification/maintenance_hours_counter_bench.sv]
// Purpose: Self-checking bench of the service hours counter over APB and its level inputs.
// Assumes: One hour is shortened to 20 enabled clocks; APB answers after a bounded wait.
// Notes:   Tick counts allow one clock of slack so the prescaler phase does not matter.

`timescale 1ns/1ns

module maintenance_hours_counter_bench;
  logic        clk;
  logic        reset;
  logic        cold_start;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] q;
  logic        e;
  logic        pready;
  logic        pslverr;
  logic        monitor_in;
  logic        interval_reset;
  logic        reset_all;
  logic        maintenance_due;
  logic        irq;
  logic [2:0]  want;
  int          fail_count;
  int          n_tests;
  int          cyc;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  service_hours_counter #(.HOUR_CYCLES(37'h00_0000_0014)) u_dut (
    .clk(clk), .reset(reset), .cold_start(cold_start), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .monitor_in(monitor_in), .interval_reset(interval_reset),
    .reset_all(reset_all), .maintenance_due(maintenance_due), .irq(irq)
  );

  logic_source u_src (
    .clk(clk), .want(want), .monitor_in(monitor_in), .interval_reset(interval_reset),
    .reset_all(reset_all)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic print_verdict();
    $display("tests=%0d errors=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  // Readiness is taken at the rising edge, the same edge at which the slave ends the transfer,
  // so data are captured and the request released exactly where the write lands.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk(32'h0000_0000, 32'h0000_0001);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask

  task automatic drive(input logic [2:0] w, input int n);
    @(posedge clk);
    want <= w;
    repeat (n) @(posedge clk);
  endtask

  task automatic start_run(input logic [31:0] iv, input logic [31:0] tot);
    int n;
    wr(hours_pkg::OFF_CTRL, 32'h0000_0000);
    wr(hours_pkg::OFF_INTERVAL, iv);
    wr(hours_pkg::OFF_TOTAL, tot);
    wr(hours_pkg::OFF_CTRL, 32'h0000_0001);
    n = 0;
    q = 32'h0000_0000;
    while (q[1] !== 1'b1 && n < 40) begin
      apb(1'b0, hours_pkg::OFF_STATUS, 32'h0000_0000);
      if (n == 0) chk(q, 32'h0000_0004);
      n++;
    end
    chk({31'h0, q[1]}, 32'h0000_0001);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic s_regs();
    logic [7:0] offs [7];
    offs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    foreach (offs[i]) rd(offs[i], 32'h0000_0000);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    wr(hours_pkg::OFF_INTERVAL, 32'h0000_3FFF);
    rd(hours_pkg::OFF_INTERVAL, 32'(hours_pkg::INTERVAL_MAX));
    wr(hours_pkg::OFF_TOTAL, 32'h0001_FFFF);
    rd(hours_pkg::OFF_TOTAL, 32'(hours_pkg::TOTAL_MAX));
    wr(hours_pkg::OFF_TTG, 32'h0000_0005);
    rd(hours_pkg::OFF_TTG, 32'h0000_0000);
  endtask

  task automatic s_count();
    start_run(32'h0000_0064, 32'h0000_0082);
    rd(hours_pkg::OFF_TTG, 32'h0000_0046);
    drive(3'b001, 65);
    drive(3'b000, 100);
    rd(hours_pkg::OFF_TOTAL, 32'h0000_0085);
    rd(hours_pkg::OFF_TTG, 32'h0000_0043);
    rd(hours_pkg::OFF_INTERVAL, 32'h0000_0064);
    drive(3'b001, 10);
    drive(3'b000, 30);
    drive(3'b001, 10);
    drive(3'b000, 5);
    rd(hours_pkg::OFF_TOTAL, 32'h0000_0086);
    drive(3'b011, 25);
    drive(3'b000, 5);
    rd(hours_pkg::OFF_TOTAL, 32'h0000_0087);
    rd(hours_pkg::OFF_TTG, 32'h0000_0063);
    drive(3'b100, 3);
    drive(3'b000, 3);
    rd(hours_pkg::OFF_TOTAL, 32'h0000_0000);
    rd(hours_pkg::OFF_TTG, 32'h0000_0064);
  endtask

  task automatic s_due();
    wr(hours_pkg::OFF_IRQ_MASK, 32'h0000_0003);
    start_run(32'h0000_0002, 32'h0001_869E);
    rd(hours_pkg::OFF_TTG, 32'h0000_0002);
    drive(3'b001, 60);
    drive(3'b000, 3);
    rd(hours_pkg::OFF_TOTAL, 32'h0001_869F);
    rd(hours_pkg::OFF_TTG, 32'h0000_0000);
    chk({31'h0, maintenance_due}, 32'h0000_0001);
    rd(hours_pkg::OFF_IRQ_STATUS, 32'h0000_0003);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(hours_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    wr(hours_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    rd(hours_pkg::OFF_IRQ_STATUS, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(hours_pkg::OFF_IRQ_MASK, 32'h0000_0003);
    drive(3'b000, 2);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(hours_pkg::OFF_CTRL, 32'h0000_0003);
    drive(3'b000, 3);
    chk({31'h0, maintenance_due}, 32'h0000_0000);
    wr(hours_pkg::OFF_CTRL, 32'h0000_0001);
    drive(3'b000, 3);
    chk({31'h0, maintenance_due}, 32'h0000_0001);
    drive(3'b010, 3);
    chk({31'h0, maintenance_due}, 32'h0000_0000);
    drive(3'b000, 3);
    chk({31'h0, maintenance_due}, 32'h0000_0000);
    rd(hours_pkg::OFF_TTG, 32'h0000_0002);
    rd(hours_pkg::OFF_TOTAL, 32'h0001_869F);
  endtask

  // A warm reset models a power cycle: the counts must come back untouched.
  task automatic s_retain();
    @(posedge clk);
    cold_start <= 1'b0;
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(hours_pkg::OFF_INTERVAL, 32'h0000_0002);
    rd(hours_pkg::OFF_TOTAL, 32'h0001_869F);
    rd(hours_pkg::OFF_TTG, 32'h0000_0002);
    rd(hours_pkg::OFF_CTRL, 32'h0000_0000);
    // A zero interval leaves no time to go, so the due output must rise at once.
    start_run(32'h0000_0000, 32'h0000_0005);
    rd(hours_pkg::OFF_TTG, 32'h0000_0000);
    chk({31'h0, maintenance_due}, 32'h0000_0001);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    reset = 1'b1;
    cold_start = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    want = 3'b000;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    s_regs();
    s_count();
    s_due();
    s_retain();
    print_verdict();
  end
endmodule
